//--- src/pdcb_params.svh
`ifndef PDCB_PARAMS_SVH
`define PDCB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Bank sizes and word layout
// ----------------------------------------------------------------------------
`define PDCB_CTR_N 64
`define PDCB_TMR_N 64
`define PDCB_WORD_W 16
`define PDCB_DONE_WORDS 4
`define PDCB_IDX_W 7
`define PDCB_IDX_FIRST 7'h01

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PDCB_PRESET_RST 16'h0001
`define PDCB_PV_RST 16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PDCB_CLK_NS 5
`define PDCB_TBASE_NS 100000000
`define PDCB_TICK_CYCLES (`PDCB_TBASE_NS / `PDCB_CLK_NS)

// ----------------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------------
`define PDCB_SEQ_STEPS 32
`define PDCB_SEQ_W 5
`define PDCB_SEQ_LAST 5'h08

`endif

//--- src/pdcb_pkg.sv
package pdcb_pkg;

  // --------------------------------------------------------------------------
  // Software command port
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    PDCB_OP_RD_CTR_PV,
    PDCB_OP_WR_CTR_PV,
    PDCB_OP_RD_TMR_PV,
    PDCB_OP_WR_TMR_PV,
    PDCB_OP_RD_CTR_DONE,
    PDCB_OP_RD_TMR_DONE,
    PDCB_OP_WR_CTR_PRESET,
    PDCB_OP_WR_TMR_PRESET,
    PDCB_OP_RD_CTR_PRESET,
    PDCB_OP_RD_TMR_PRESET
  } pdcb_op_t;

  typedef struct packed {
    logic valid;
    pdcb_op_t op;
    logic [6:0] index;
    logic [15:0] data;
  } pdcb_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } pdcb_rsp_t;

endpackage

//--- src/pdcb_sync.sv
`timescale 1ns/1ps
module pdcb_sync #(
  parameter int W = 1
) (
  input logic clock,
  input logic rstn,
  input logic clk_en,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule // pdcb_sync

//--- src/pdcb_sequencer.sv
`timescale 1ns/1ps
`include "pdcb_params.svh"
module pdcb_sequencer #(
  parameter logic [`PDCB_SEQ_W-1:0] LAST = `PDCB_SEQ_LAST
) (
  input logic clock,
  input logic rstn,
  input logic clk_en,
  input logic advance,
  output logic [`PDCB_SEQ_W-1:0] step,
  output logic [`PDCB_SEQ_STEPS-1:0] step_hot
);

  logic [`PDCB_SEQ_W-1:0] step_r;
  logic [`PDCB_SEQ_W-1:0] step_nxt;
  logic [`PDCB_SEQ_STEPS-1:0] hot_r;

  always_comb begin
    step_nxt = step_r;
    if (advance) begin
      if (step_r >= LAST) begin
        step_nxt = '0;
      end else begin
        step_nxt = step_r + 1'b1;
      end
    end
  end

  // The decoded step is registered with the count so both change on the same edge.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      step_r <= '0;
      hot_r <= `PDCB_SEQ_STEPS'h1;
    end else if (clk_en) begin
      step_r <= step_nxt;
      hot_r <= `PDCB_SEQ_STEPS'(1) << step_nxt;
    end
  end

  assign step = step_r;
  assign step_hot = hot_r;

  a_seq_wrap: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && advance && step_r == LAST |=> step_r == '0)
    else $error("sequencer did not return to the initial step");

  a_seq_decode: assert property (@(posedge clock) disable iff (!rstn)
    hot_r == (`PDCB_SEQ_STEPS'(1) << step_r))
    else $error("decoded step does not match step counter");

endmodule // pdcb_sequencer

//--- src/pdcb_bank.sv
`timescale 1ns/1ps
`include "pdcb_params.svh"
module pdcb_bank #(
  parameter int CTR_N = `PDCB_CTR_N,
  parameter int TMR_N = `PDCB_TMR_N,
  parameter int TICK_CYCLES = `PDCB_TICK_CYCLES,
  parameter logic [`PDCB_SEQ_W-1:0] SEQ_LAST = `PDCB_SEQ_LAST
) (
  input logic clock,
  input logic rstn,
  input logic clk_en,
  input logic [CTR_N-1:0] counter_coil,
  input logic [CTR_N-1:0] counter_clear_function,
  input logic [TMR_N-1:0] timer_coil,
  input logic seq_advance,
  input pdcb_pkg::pdcb_req_t req,
  output pdcb_pkg::pdcb_rsp_t rsp,
  output logic [CTR_N-1:0] counter_done,
  output logic [TMR_N-1:0] timer_done,
  output logic [`PDCB_SEQ_W-1:0] seq_step,
  output logic [`PDCB_SEQ_STEPS-1:0] seq_step_hot
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int PIN_W = 2 * CTR_N + TMR_N + 1;

  // --------------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] pins_q;
  logic [CTR_N-1:0] ctr_coil_q;
  logic [CTR_N-1:0] ctr_clr_q;
  logic [TMR_N-1:0] tmr_coil_q;
  logic seq_adv_q;
  logic [CTR_N-1:0] ctr_prev_r;
  logic seq_prev_r;
  logic [CTR_N-1:0] ctr_rise;
  logic seq_pulse;
  pdcb_sync #(.W(PIN_W)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .d({seq_advance, timer_coil, counter_clear_function, counter_coil}),
    .q(pins_q)
  );
  assign ctr_coil_q = pins_q[CTR_N-1:0];
  assign ctr_clr_q = pins_q[2*CTR_N-1:CTR_N];
  assign tmr_coil_q = pins_q[2*CTR_N+TMR_N-1:2*CTR_N];
  assign seq_adv_q = pins_q[PIN_W-1];
  // Previous scan starts at zero, so a coil already on at reset counts as a first energize.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctr_prev_r <= '0;
      seq_prev_r <= 1'b0;
    end else if (clk_en) begin
      ctr_prev_r <= ctr_coil_q;
      seq_prev_r <= seq_adv_q;
    end
  end
  assign ctr_rise = ctr_coil_q & ~ctr_prev_r;
  assign seq_pulse = seq_adv_q & ~seq_prev_r;

  // --------------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      if (tick) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

  // --------------------------------------------------------------------------
  // Software command decode
  // --------------------------------------------------------------------------
  function automatic logic idx_ok(input logic [`PDCB_IDX_W-1:0] idx, input int hi);
    return (idx >= `PDCB_IDX_FIRST) && (int'(idx) <= hi);
  endfunction
  function automatic logic [5:0] slot_of(input logic [`PDCB_IDX_W-1:0] idx);
    return 6'(idx - `PDCB_IDX_FIRST);
  endfunction
  logic [5:0] slot;
  logic [1:0] word_sel;
  logic pv_idx_ok;
  logic word_idx_ok;
  logic [CTR_N-1:0] ctr_pv_wr;
  logic [TMR_N-1:0] tmr_pv_wr;
  logic [CTR_N-1:0] ctr_pre_wr;
  logic [TMR_N-1:0] tmr_pre_wr;
  assign slot = slot_of(req.index);
  assign word_sel = slot[1:0];
  assign pv_idx_ok = idx_ok(req.index, CTR_N);
  assign word_idx_ok = idx_ok(req.index, `PDCB_DONE_WORDS);
  always_comb begin
    ctr_pv_wr = '0;
    tmr_pv_wr = '0;
    ctr_pre_wr = '0;
    tmr_pre_wr = '0;
    if (req.valid && pv_idx_ok) begin
      if (req.op == pdcb_pkg::PDCB_OP_WR_CTR_PV) begin
        ctr_pv_wr[slot] = 1'b1;
      end else if (req.op == pdcb_pkg::PDCB_OP_WR_TMR_PV) begin
        tmr_pv_wr[slot] = 1'b1;
      end else if (req.op == pdcb_pkg::PDCB_OP_WR_CTR_PRESET) begin
        ctr_pre_wr[slot] = 1'b1;
      end else if (req.op == pdcb_pkg::PDCB_OP_WR_TMR_PRESET) begin
        tmr_pre_wr[slot] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Preset store
  // --------------------------------------------------------------------------
  logic [`PDCB_WORD_W-1:0] ctr_preset_r [CTR_N];
  logic [`PDCB_WORD_W-1:0] tmr_preset_r [TMR_N];
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctr_preset_r <= '{default: `PDCB_PRESET_RST};
      tmr_preset_r <= '{default: `PDCB_PRESET_RST};
    end else if (clk_en) begin
      if (ctr_pre_wr[slot]) begin
        ctr_preset_r[slot] <= req.data;
      end
      if (tmr_pre_wr[slot]) begin
        tmr_preset_r[slot] <= req.data;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  logic [`PDCB_WORD_W-1:0] ctr_pv_r [CTR_N];
  logic [`PDCB_WORD_W-1:0] ctr_pv_nxt [CTR_N];
  logic [CTR_N-1:0] ctr_loaded_r;
  logic [CTR_N-1:0] ctr_loaded_nxt;
  logic [CTR_N-1:0] ctr_done_r;
  logic [CTR_N-1:0] ctr_done_nxt;
  // A clear and a coil edge in the same scan are both honoured: the clear empties the
  // counter first, then the edge acts as a first energize, so no count is lost.
  always_comb begin
    for (int i = 0; i < CTR_N; i++) begin
      ctr_pv_nxt[i] = ctr_pv_r[i];
      ctr_loaded_nxt[i] = ctr_loaded_r[i];
      ctr_done_nxt[i] = ctr_done_r[i];
      if (ctr_clr_q[i]) begin
        ctr_loaded_nxt[i] = 1'b0;
        ctr_done_nxt[i] = 1'b0;
      end
      if (ctr_rise[i]) begin
        if (!ctr_loaded_nxt[i]) begin
          ctr_loaded_nxt[i] = 1'b1;
          if (ctr_preset_r[i] != '0) begin
            ctr_pv_nxt[i] = ctr_preset_r[i] - 1'b1;
          end else begin
            ctr_pv_nxt[i] = '0;
          end
        end else if (ctr_pv_nxt[i] != '0) begin
          ctr_pv_nxt[i] = ctr_pv_nxt[i] - 1'b1;
        end
      end
      if (ctr_pv_wr[i]) begin
        ctr_pv_nxt[i] = req.data;
        ctr_loaded_nxt[i] = 1'b1;
      end
      if (ctr_loaded_nxt[i] && ctr_pv_nxt[i] == '0) begin
        ctr_done_nxt[i] = 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctr_pv_r <= '{default: `PDCB_PV_RST};
      ctr_loaded_r <= '0;
      ctr_done_r <= '0;
    end else if (clk_en) begin
      ctr_pv_r <= ctr_pv_nxt;
      ctr_loaded_r <= ctr_loaded_nxt;
      ctr_done_r <= ctr_done_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------
  logic [`PDCB_WORD_W-1:0] tmr_pv_r [TMR_N];
  logic [`PDCB_WORD_W-1:0] tmr_pv_nxt [TMR_N];
  logic [TMR_N-1:0] tmr_run_r;
  logic [TMR_N-1:0] tmr_run_nxt;
  logic [TMR_N-1:0] tmr_done_r;
  logic [TMR_N-1:0] tmr_done_nxt;
  // Dropping the coil aborts the delay; the next energize restarts from the preset.
  always_comb begin
    for (int i = 0; i < TMR_N; i++) begin
      tmr_pv_nxt[i] = tmr_pv_r[i];
      tmr_run_nxt[i] = tmr_run_r[i];
      if (!tmr_coil_q[i]) begin
        tmr_run_nxt[i] = 1'b0;
      end else if (!tmr_run_r[i]) begin
        tmr_run_nxt[i] = 1'b1;
        tmr_pv_nxt[i] = tmr_preset_r[i];
      end else if (tick && tmr_pv_r[i] != '0) begin
        tmr_pv_nxt[i] = tmr_pv_r[i] - 1'b1;
      end
      if (tmr_pv_wr[i]) begin
        tmr_pv_nxt[i] = req.data;
        tmr_run_nxt[i] = tmr_coil_q[i];
      end
      tmr_done_nxt[i] = tmr_run_nxt[i] && tmr_pv_nxt[i] == '0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tmr_pv_r <= '{default: `PDCB_PV_RST};
      tmr_run_r <= '0;
      tmr_done_r <= '0;
    end else if (clk_en) begin
      tmr_pv_r <= tmr_pv_nxt;
      tmr_run_r <= tmr_run_nxt;
      tmr_done_r <= tmr_done_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Software answers
  // --------------------------------------------------------------------------
  pdcb_pkg::pdcb_rsp_t rsp_r;
  // Reads return the value held before any write in the same cycle takes effect.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rsp_r <= '0;
    end else if (clk_en) begin
      rsp_r.valid <= req.valid;
      rsp_r.err <= 1'b0;
      rsp_r.data <= '0;
      if (req.valid) begin
        if (req.op == pdcb_pkg::PDCB_OP_RD_CTR_DONE || req.op == pdcb_pkg::PDCB_OP_RD_TMR_DONE) begin
          if (!word_idx_ok) begin
            rsp_r.err <= 1'b1;
          end else if (req.op == pdcb_pkg::PDCB_OP_RD_CTR_DONE) begin
            rsp_r.data <= ctr_done_r[`PDCB_WORD_W*word_sel +: `PDCB_WORD_W];
          end else begin
            rsp_r.data <= tmr_done_r[`PDCB_WORD_W*word_sel +: `PDCB_WORD_W];
          end
        end else if (!pv_idx_ok) begin
          rsp_r.err <= 1'b1;
        end else if (req.op == pdcb_pkg::PDCB_OP_RD_CTR_PV) begin
          rsp_r.data <= ctr_pv_r[slot];
        end else if (req.op == pdcb_pkg::PDCB_OP_RD_TMR_PV) begin
          rsp_r.data <= tmr_pv_r[slot];
        end else if (req.op == pdcb_pkg::PDCB_OP_RD_CTR_PRESET) begin
          rsp_r.data <= ctr_preset_r[slot];
        end else if (req.op == pdcb_pkg::PDCB_OP_RD_TMR_PRESET) begin
          rsp_r.data <= tmr_preset_r[slot];
        end
      end
    end
  end
  assign rsp = rsp_r;
  assign counter_done = ctr_done_r;
  assign timer_done = tmr_done_r;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  pdcb_sequencer #(.LAST(SEQ_LAST)) u_seq (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .advance(seq_pulse),
    .step(seq_step),
    .step_hot(seq_step_hot)
  );

  // --------------------------------------------------------------------------
  // Checks on counter 0, timer 0 and the command port
  // --------------------------------------------------------------------------
  logic hw_only0;
  assign hw_only0 = clk_en && !ctr_clr_q[0] && !ctr_pv_wr[0];

  a_first_load: assert property (@(posedge clock) disable iff (!rstn)
    hw_only0 && ctr_rise[0] && !ctr_loaded_r[0] && ctr_preset_r[0] != '0
    |=> ctr_loaded_r[0] && ctr_pv_r[0] == $past(ctr_preset_r[0]) - 16'h0001)
    else $error("first energize did not load preset minus one");
  a_edge_decrement: assert property (@(posedge clock) disable iff (!rstn)
    hw_only0 && ctr_rise[0] && ctr_loaded_r[0] && ctr_pv_r[0] != '0
    |=> ctr_pv_r[0] == $past(ctr_pv_r[0]) - 16'h0001) else $error("rising coil edge did not decrement by one");
  a_steady_hold: assert property (@(posedge clock) disable iff (!rstn)
    hw_only0 && ctr_coil_q[0] && ctr_prev_r[0] ##1 hw_only0 && ctr_coil_q[0]
    |=> $stable(ctr_pv_r[0])) else $error("steady coil changed the count");
  a_zero_done: assert property (@(posedge clock) disable iff (!rstn)
    ctr_loaded_r[0] && ctr_pv_r[0] == '0 |-> ctr_done_r[0]) else $error("count at zero without done contact");
  a_done_sticky: assert property (@(posedge clock) disable iff (!rstn)
    ctr_done_r[0] && !(clk_en && ctr_clr_q[0]) |=> ctr_done_r[0]) else $error("done dropped without a clear");
  a_clear_done: assert property (@(posedge clock) disable iff (!rstn)
    $fell(ctr_done_r[0]) |-> $past(ctr_clr_q[0]) && $past(clk_en)) else $error("done fell without a clear");
  a_clear_unload: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && ctr_clr_q[0] && !ctr_rise[0] && !ctr_pv_wr[0] |=> !ctr_loaded_r[0] && !ctr_done_r[0])
    else $error("clear did not return counter to unloaded");
  a_timer_done: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && tmr_run_r[0] && tmr_coil_q[0] && !tmr_pv_wr[0] && tick && tmr_pv_r[0] == 16'h0001
    |=> tmr_done_r[0] && tmr_pv_r[0] == '0) else $error("timer done missing after final tick");
  a_pv_read: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == pdcb_pkg::PDCB_OP_RD_CTR_PV && req.index == `PDCB_IDX_FIRST
    |=> rsp.valid && !rsp.err && rsp.data == $past(ctr_pv_r[0])) else $error("counter value read mismatch");
  a_word_read: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == pdcb_pkg::PDCB_OP_RD_TMR_DONE && req.index == `PDCB_IDX_FIRST
    |=> rsp.valid && rsp.data == $past(tmr_done_r[15:0])) else $error("timer done word read mismatch");
  a_preset_write: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == pdcb_pkg::PDCB_OP_WR_CTR_PRESET && req.index == `PDCB_IDX_FIRST
    |=> ctr_preset_r[0] == $past(req.data)) else $error("counter preset write lost");

endmodule // pdcb_bank

//--- tb/tb_plc_down_counter_bank.sv
`timescale 1ns/1ps
`include "pdcb_params.svh"
module tb_plc_down_counter_bank;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [63:0] counter_coil = '0;
  logic [63:0] counter_clear_function = '0;
  logic [63:0] timer_coil = '0;
  logic seq_advance = 1'b0;
  pdcb_pkg::pdcb_req_t req = '0;
  pdcb_pkg::pdcb_rsp_t rsp;
  logic [63:0] counter_done;
  logic [63:0] timer_done;
  logic [`PDCB_SEQ_W-1:0] seq_step;
  logic [`PDCB_SEQ_STEPS-1:0] seq_step_hot;
  int fail_count = 0;
  int n_compared = 0;
  // ---------------------------------------------------------------------------
  // Reference model of the counters
  // ---------------------------------------------------------------------------
  int m_pre [1:64];
  int m_pv [1:64];
  bit m_ld [1:64];
  bit m_done [1:64];
  logic [15:0] rd;
  logic er;
  int k;

  always #2.5 clock = ~clock;

  // A short tick period keeps the timer scenario within a few dozen cycles.
  pdcb_bank #(.CTR_N(64), .TMR_N(64), .TICK_CYCLES(4)) dut (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .counter_coil(counter_coil),
    .counter_clear_function(counter_clear_function),
    .timer_coil(timer_coil),
    .seq_advance(seq_advance),
    .req(req),
    .rsp(rsp),
    .counter_done(counter_done),
    .timer_done(timer_done),
    .seq_step(seq_step),
    .seq_step_hot(seq_step_hot)
  );

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One request, taken at the next rising edge; the answer is sampled a cycle on.
  task automatic cmd(input pdcb_pkg::pdcb_op_t op, input int idx, input int d);
    @(negedge clock);
    req = '{valid: 1'b1, op: op, index: 7'(idx), data: 16'(d)};
    @(negedge clock);
    req.valid = 1'b0;
    chk(64'(rsp.valid), 64'h1);
    rd = rsp.data;
    er = rsp.err;
  endtask

  // Pins pass a two-flop synchroniser, so each level is held for several cycles.
  task automatic coil_pulse(input int i, input int hold);
    @(negedge clock);
    counter_coil[i-1] = 1'b1;
    waitc(hold);
    counter_coil[i-1] = 1'b0;
    waitc(5);
    if (!m_ld[i]) begin
      m_pv[i] = (m_pre[i] > 0) ? m_pre[i] - 1 : 0;
      m_ld[i] = 1'b1;
    end else if (m_pv[i] > 0) begin
      m_pv[i]--;
    end
    if (m_pv[i] == 0) m_done[i] = 1'b1;
  endtask

  task automatic ctr_test(input int i, input int pre);
    cmd(pdcb_pkg::PDCB_OP_WR_CTR_PRESET, i, pre);
    chk(64'(er), 64'h0);
    m_pre[i] = pre;
    cmd(pdcb_pkg::PDCB_OP_RD_CTR_PRESET, i, 0);
    chk(64'(rd), 64'(pre));
    coil_pulse(i, 15);
    cmd(pdcb_pkg::PDCB_OP_RD_CTR_PV, i, 0);
    chk(64'(rd), 64'(m_pv[i]));
    while (!m_done[i]) begin
      chk(64'(counter_done[i-1]), 64'h0);
      coil_pulse(i, 4);
      cmd(pdcb_pkg::PDCB_OP_RD_CTR_PV, i, 0);
      chk(64'(rd), 64'(m_pv[i]));
    end
    chk(64'(counter_done[i-1]), 64'h1);
    @(negedge clock);
    counter_coil[i-1] = 1'b1;
    waitc(6);
    chk(64'(counter_done[i-1]), 64'h1);
    counter_coil[i-1] = 1'b0;
    waitc(6);
    chk(64'(counter_done[i-1]), 64'h1);
  endtask

  task automatic ctr_clear(input int i);
    @(negedge clock);
    counter_clear_function[i-1] = 1'b1;
    waitc(5);
    counter_clear_function[i-1] = 1'b0;
    waitc(5);
    m_ld[i] = 1'b0;
    m_done[i] = 1'b0;
    chk(64'(counter_done[i-1]), 64'h0);
    coil_pulse(i, 4);
    cmd(pdcb_pkg::PDCB_OP_RD_CTR_PV, i, 0);
    chk(64'(rd), 64'(m_pv[i]));
  endtask

  function automatic logic [15:0] done_word(input int n);
    logic [15:0] w;
    for (int b = 0; b < 16; b++) w[b] = m_done[16*(n-1)+b+1];
    return w;
  endfunction

  initial begin
    k = $urandom(32'h94eca5c1);
    for (int i = 1; i <= 64; i++) begin
      m_pre[i] = 1;
      m_pv[i] = 0;
      m_ld[i] = 1'b0;
      m_done[i] = 1'b0;
    end
    waitc(6);
    chk(64'(rsp), 64'h0);
    chk({counter_done}, 64'h0);
    chk(64'(seq_step_hot), 64'h1);
    rstn = 1'b1;
    waitc(2);
    // -------------------------------------------------------------------------
    // Counting, latching and clearing
    // -------------------------------------------------------------------------
    ctr_test(1, 3);
    k = 2 + ($urandom % 63);
    ctr_test(k, 2 + ($urandom % 4));
    ctr_clear(1);
    for (int n = 1; n <= 4; n++) begin
      cmd(pdcb_pkg::PDCB_OP_RD_CTR_DONE, n, 0);
      chk(64'(rd), 64'(done_word(n)));
    end
    // -------------------------------------------------------------------------
    // Timer delay and done contact
    // -------------------------------------------------------------------------
    cmd(pdcb_pkg::PDCB_OP_WR_TMR_PRESET, 1, 2);
    chk(64'(er), 64'h0);
    cmd(pdcb_pkg::PDCB_OP_RD_TMR_PRESET, 1, 0);
    chk(64'(rd), 64'h2);
    @(negedge clock);
    timer_coil[0] = 1'b1;
    waitc(4);
    chk(64'(timer_done[0]), 64'h0);
    k = 0;
    while (timer_done[0] !== 1'b1 && k < 100) begin
      waitc(1);
      k++;
    end
    chk(64'(timer_done[0]), 64'h1);
    cmd(pdcb_pkg::PDCB_OP_RD_TMR_PV, 1, 0);
    chk(64'(rd), 64'h0);
    cmd(pdcb_pkg::PDCB_OP_RD_TMR_DONE, 1, 0);
    chk(64'(rd), 64'h1);
    timer_coil[0] = 1'b0;
    waitc(6);
    chk(64'(timer_done[0]), 64'h0);
    // -------------------------------------------------------------------------
    // Present values at both ends of the index range, and refusals
    // -------------------------------------------------------------------------
    foreach (m_pre[i]) begin
      if (i == 1 || i == 64) begin
        k = 1 + ($urandom % 9000);
        cmd(pdcb_pkg::PDCB_OP_WR_CTR_PV, i, k);
        cmd(pdcb_pkg::PDCB_OP_RD_CTR_PV, i, 0);
        chk(64'(rd), 64'(k));
        cmd(pdcb_pkg::PDCB_OP_WR_TMR_PV, i, k + 1);
        cmd(pdcb_pkg::PDCB_OP_RD_TMR_PV, i, 0);
        chk(64'(rd), 64'(k + 1));
      end
    end
    cmd(pdcb_pkg::PDCB_OP_RD_CTR_PV, 0, 0);
    chk({rd, 47'h0, er}, 64'h1);
    cmd(pdcb_pkg::PDCB_OP_RD_TMR_PV, 65, 0);
    chk({rd, 47'h0, er}, 64'h1);
    cmd(pdcb_pkg::PDCB_OP_RD_CTR_DONE, 5, 0);
    chk({rd, 47'h0, er}, 64'h1);
    // -------------------------------------------------------------------------
    // Sequencer steps through to the last step and wraps
    // -------------------------------------------------------------------------
    for (int s = 1; s <= 10; s++) begin
      seq_advance = 1'b1;
      waitc(5);
      seq_advance = 1'b0;
      waitc(5);
      chk(64'(seq_step), 64'(s % 9));
      chk(64'(seq_step_hot), 64'h1 << (s % 9));
    end
    // With the clock enable low the pins are not sampled, so this advance pulse must be lost.
    clk_en = 1'b0;
    seq_advance = 1'b1;
    waitc(5);
    seq_advance = 1'b0;
    waitc(5);
    clk_en = 1'b1;
    waitc(5);
    chk(64'(seq_step), 64'h1);
    test_done();
  end

  initial begin
    #500000;
    fail_count++;
    test_done();
  end
endmodule // tb_plc_down_counter_bank
